// ==== design/sfrp_pkg.sv ====
// Package with opcodes, widths and defaults of the serial flash read path.
package sfrp_pkg;
	localparam logic [7:0] NORMAL_READ_CMD           = 8'h03;
	localparam logic [7:0] NORMAL_READ_WIDE_ADDR_CMD = 8'h13;
	localparam logic [7:0] FAST_READ_CMD             = 8'h0B;
	localparam logic [7:0] FAST_READ_WIDE_ADDR_CMD   = 8'h0C;
	localparam logic [7:0] QUAD_IO_READ_CMD          = 8'hEB;
	localparam logic [7:0] UNIQUE_ID_READ_CMD        = 8'h4B;
	localparam logic [7:0] INFO_ROW_READ_CMD         = 8'h68;
	localparam logic [3:0] CONTINUATION_MODE_NIBBLE  = 4'hA;
	localparam logic [4:0] SPI_DUMMY_DEFAULT         = 5'h08;
	localparam logic [4:0] QPI_DUMMY_DEFAULT         = 5'h06;
	localparam logic [5:0] ADDR_BITS_NARROW          = 6'h18;
	localparam logic [5:0] ADDR_BITS_WIDE            = 6'h20;
	localparam int         ADDR_VALID_BITS_LARGE     = 25;
	localparam int         ADDR_VALID_BITS_SMALL     = 24;
	localparam logic [31:0] ADDR_ZERO                = 32'h0000_0000;
	localparam logic [5:0] OPCODE_BITS               = 6'h08;
	localparam logic [4:0] DUMMY_ZERO                = 5'h00;

	typedef enum logic [2:0] {
		SFRP_IDLE,
		SFRP_OPCODE,
		SFRP_ADDR,
		SFRP_DUMMY,
		SFRP_DATA,
		SFRP_IGNORE
	} sfrp_state_t;
endpackage

// ==== design/sfrp_sync.sv ====
// Two-stage synchroniser for asynchronous pin inputs.
module sfrp_sync #(
	parameter int        WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sfrp_sync_t;

	sfrp_sync_t cur;
	sfrp_sync_t next_cur;

	always_comb
	begin
		next_cur.meta = async_i;
		next_cur.stable = cur.meta;
		if (srst_i)
		begin
			next_cur.meta = INIT;
			next_cur.stable = INIT;
		end
	end

	always_ff @(posedge clk_i)
	begin
		cur <= next_cur;
	end

	assign sync_o = cur.stable;
endmodule

// ==== design/sfrp_top.sv ====
// Read-command path of a serial flash, sampled by the system clock.
// Notes on behaviour
// - 03h normal read, 13h always four-byte address.
// - Shift 24/32 address bits, decode valid bits only.
// - Large part decodes A24-A0 wide; small A23-A0.
// - Normal read data leaves MSB first.
// - Address increments per byte, wraps to zero.
// - Chip select high stops output, ends command.
// - Serial input ignored once the data phase starts.
// - Reads ignored if write in progress at opcode end; continuation reads are not.
// - 0Bh fast read follows mode; 0Ch wide.
// - Fast read dummies; sample rising, drive falling.
// - Four-line mode: opcode 2, address 6/8 clocks.
// - Four-line fast read dummies default six.
// - EBh, 4Bh, 68h four-line; latter narrow addresses.
// - Continuation mode byte clocks count as dummies.
// - Hold low with clock low pauses, keeps state.
// - Hold release resumes; output off, input ignored.
// - Hold disabled in DTR, quad enable, reset-pin.
module sfrp_top
	import sfrp_pkg::*;
#(
	parameter bit        LARGE_DENSITY = 1'b1,
	parameter logic [4:0] SPI_DUMMY    = sfrp_pkg::SPI_DUMMY_DEFAULT,
	parameter logic [4:0] QPI_DUMMY    = sfrp_pkg::QPI_DUMMY_DEFAULT
) (
	input  wire logic        SYS_CLK_I,
	input  wire logic        SRST_I,
	input  wire logic        CHIP_SEL_N_I,
	input  wire logic        SER_CLK_I,
	input  wire logic        HOLD_N_I,
	input  wire logic [3:0]  IO_I,
	output logic      [3:0]  IO_O,
	output logic      [3:0]  IO_OE_O,
	input  wire logic        EXTENDED_ADDRESSING_FLAG_I,
	input  wire logic        WRITE_IN_PROGRESS_FLAG_I,
	input  wire logic        QUAD_ENABLE_FLAG_I,
	input  wire logic        FOUR_LINE_COMMAND_MODE_I,
	input  wire logic        DTR_MODE_I,
	input  wire logic        HOLD_PIN_IS_RESET_I,
	output logic             MEM_RD_REQ_O,
	output logic      [31:0] MEM_ADDR_O,
	input  wire logic [7:0]  MEM_DATA_I,
	output logic             BUSY_O,
	output logic             CONT_MODE_O
);
	import sfrp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the memory data comes from same-clock logic.

	logic [3:0] pin_sync;
	logic [3:0] io_sync;

	sfrp_sync #(
		.WIDTH (4),
		.INIT  (4'hD)
	) u_pin_sync (
		.clk_i   (SYS_CLK_I),
		.srst_i  (SRST_I),
		.async_i ({HOLD_N_I, CHIP_SEL_N_I, SER_CLK_I, 1'b1}),
		.sync_o  (pin_sync)
	);

	sfrp_sync #(
		.WIDTH (4),
		.INIT  (4'h0)
	) u_io_sync (
		.clk_i   (SYS_CLK_I),
		.srst_i  (SRST_I),
		.async_i (IO_I),
		.sync_o  (io_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// State of the sequencer.

	typedef struct packed {
		sfrp_state_t  state;
		logic         sclk_d;
		logic         held;
		logic         quad;
		logic         wide;
		logic         fast;
		logic         cont;
		logic [5:0]   cnt;
		logic [5:0]   addr_bits;
		logic [7:0]   opcode;
		logic [31:0]  addr;
		logic [7:0]   mode_byte;
		logic [7:0]   shreg;
		logic [3:0]   io;
		logic [3:0]   io_oe;
		logic         rd_req;
		logic         busy;
	} sfrp_regs_t;

	sfrp_regs_t cur;
	sfrp_regs_t next_cur;

	logic        sclk;
	logic        cs_n;
	logic        hold_n;
	logic        rise;
	logic        fall;
	logic        hold_ok;
	logic [3:0]  lanes;
	logic [5:0]  step;
	logic [31:0] addr_shift;
	logic [31:0] addr_mask;
	logic [7:0]  op_next;

	assign sclk = pin_sync[1];
	assign cs_n = pin_sync[2];
	assign hold_n = pin_sync[3];
	assign rise = sclk && !cur.sclk_d;
	assign fall = !sclk && cur.sclk_d;
	// Hold has no effect in DTR, quad enable or reset-pin configurations.
	assign hold_ok = !DTR_MODE_I && !QUAD_ENABLE_FLAG_I
		&& !HOLD_PIN_IS_RESET_I;
	assign step = cur.quad ? 6'h04 : 6'h01;
	assign lanes = cur.quad ? io_sync : {3'h0, io_sync[0]};
	assign op_next = cur.quad ? {cur.opcode[3:0], lanes}
		: {cur.opcode[6:0], lanes[0]};
	assign addr_shift = cur.quad ? {cur.addr[27:0], lanes}
		: {cur.addr[30:0], lanes[0]};
	// Only address bits up to the valid MSB are decoded.
	assign addr_mask = (LARGE_DENSITY && cur.wide)
		? 32'h01FF_FFFF : 32'h00FF_FFFF;

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	always_comb
	begin
		next_cur = cur;
		next_cur.sclk_d = sclk;
		next_cur.rd_req = 1'b0;
		next_cur.busy = cur.state != SFRP_IDLE;
		// Hold is entered and left while the serial clock is low; deselect or a disabled hold clears it at any clock level.
		if (hold_ok && !sclk && !cs_n && cur.state != SFRP_IDLE)
			next_cur.held = !hold_n;
		else if (!hold_ok || cs_n)
			next_cur.held = 1'b0;
		if (cs_n)
		begin
			next_cur.state = SFRP_IDLE;
			next_cur.io_oe = 4'h0;
			next_cur.held = 1'b0;
		end
		else if (cur.held)
		begin
			next_cur.io_oe = 4'h0;
		end
		else
		begin
			next_cur.io_oe = cur.io_oe;
			unique case (cur.state)
				SFRP_IDLE:
				begin
					next_cur.quad = FOUR_LINE_COMMAND_MODE_I;
					next_cur.opcode = 8'h00;
					next_cur.addr = ADDR_ZERO;
					next_cur.cnt = 6'h00;
					next_cur.io_oe = 4'h0;
					if (cur.cont)
					begin
						next_cur.wide = EXTENDED_ADDRESSING_FLAG_I;
						next_cur.addr_bits = EXTENDED_ADDRESSING_FLAG_I
							? ADDR_BITS_WIDE : ADDR_BITS_NARROW;
						next_cur.state = SFRP_ADDR;
					end
					else
						next_cur.state = SFRP_OPCODE;
				end
				SFRP_OPCODE:
				begin
					if (rise)
					begin
						next_cur.opcode = op_next;
						next_cur.cnt = cur.cnt + step;
						if (cur.cnt + step == OPCODE_BITS)
						begin
							next_cur.cnt = 6'h00;
							next_cur.state = SFRP_ADDR;
							next_cur.fast = 1'b1;
							next_cur.wide = EXTENDED_ADDRESSING_FLAG_I;
							unique case (op_next)
								NORMAL_READ_CMD:
									next_cur.fast = 1'b0;
								NORMAL_READ_WIDE_ADDR_CMD:
								begin
									next_cur.fast = 1'b0;
									next_cur.wide = 1'b1;
								end
								FAST_READ_CMD:
									next_cur.wide = EXTENDED_ADDRESSING_FLAG_I;
								FAST_READ_WIDE_ADDR_CMD:
									next_cur.wide = 1'b1;
								QUAD_IO_READ_CMD:
									if (!cur.quad)
										next_cur.state = SFRP_IGNORE;
								UNIQUE_ID_READ_CMD, INFO_ROW_READ_CMD:
									if (cur.quad)
										next_cur.wide = 1'b0;
									else
										next_cur.state = SFRP_IGNORE;
								default:
									next_cur.state = SFRP_IGNORE;
							endcase
							// Reads are refused while a write is running.
							if (WRITE_IN_PROGRESS_FLAG_I)
								next_cur.state = SFRP_IGNORE;
							if (op_next == NORMAL_READ_CMD
								|| op_next == NORMAL_READ_WIDE_ADDR_CMD)
								if (cur.quad)
									next_cur.state = SFRP_IGNORE;
							next_cur.addr_bits = next_cur.wide
								? ADDR_BITS_WIDE : ADDR_BITS_NARROW;
						end
					end
				end
				SFRP_ADDR:
				begin
					if (rise)
					begin
						next_cur.addr = addr_shift;
						next_cur.cnt = cur.cnt + step;
						if (cur.cnt + step == cur.addr_bits)
						begin
							next_cur.cnt = 6'h00;
							next_cur.mode_byte = 8'h00;
							next_cur.state = cur.fast
								? SFRP_DUMMY : SFRP_DATA;
							next_cur.addr = addr_shift & (
								(LARGE_DENSITY && cur.wide)
								? 32'h01FF_FFFF : 32'h00FF_FFFF);
							next_cur.rd_req = !cur.fast;
						end
					end
				end
				SFRP_DUMMY:
				begin
					if (rise)
					begin
						// The mode byte is caught inside the dummy window.
						if (cur.cnt < 6'(OPCODE_BITS / step))
							next_cur.mode_byte = cur.quad
								? {cur.mode_byte[3:0], lanes}
								: {cur.mode_byte[6:0], lanes[0]};
						next_cur.cnt = cur.cnt + 6'h01;
						if (cur.cnt + 6'h01 == {1'b0, cur.quad
							? QPI_DUMMY : SPI_DUMMY})
						begin
							next_cur.cnt = 6'h00;
							next_cur.state = SFRP_DATA;
							next_cur.rd_req = 1'b1;
							next_cur.cont = cur.quad && next_cur.mode_byte[7:4]
								== CONTINUATION_MODE_NIBBLE;
						end
					end
				end
				SFRP_DATA:
				begin
					// Serial input is no longer sampled here.
					if (fall)
					begin
						if (cur.cnt == 6'h00)
							next_cur.shreg = MEM_DATA_I;
						else
							next_cur.shreg = cur.quad
								? {cur.shreg[3:0], 4'h0}
								: {cur.shreg[6:0], 1'b0};
						next_cur.io = cur.quad
							? (cur.cnt == 6'h00 ? MEM_DATA_I[7:4]
								: cur.shreg[3:0])
							: {2'h0, (cur.cnt == 6'h00
								? MEM_DATA_I[7] : cur.shreg[6]), 1'b0};
						next_cur.io_oe = cur.quad ? 4'hF : 4'h2;
						next_cur.cnt = cur.cnt + step;
						if (cur.cnt + step == OPCODE_BITS)
						begin
							next_cur.cnt = 6'h00;
							next_cur.addr = (cur.addr + 32'h1)
								& addr_mask;
							next_cur.rd_req = 1'b1;
						end
					end
				end
				SFRP_IGNORE:
				begin
					next_cur.io_oe = 4'h0;
				end
			endcase
		end
		if (SRST_I)
		begin
			next_cur = '0;
			next_cur.state = SFRP_IDLE;
			next_cur.sclk_d = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		cur <= next_cur;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from the registered state.

	assign IO_O = cur.io;
	assign IO_OE_O = cur.io_oe;
	assign MEM_RD_REQ_O = cur.rd_req;
	assign MEM_ADDR_O = cur.addr;
	assign BUSY_O = cur.busy;
	assign CONT_MODE_O = cur.cont;
endmodule

// ==== verif/sfrp_top_sva.sv ====
// Port checks for the serial flash read path.
module sfrp_top_sva (
	input wire logic        SYS_CLK_I,
	input wire logic        SRST_I,
	input wire logic        CHIP_SEL_N_I,
	input wire logic        SER_CLK_I,
	input wire logic        HOLD_N_I,
	input wire logic [3:0]  IO_OE_O,
	input wire logic        QUAD_ENABLE_FLAG_I,
	input wire logic        FOUR_LINE_COMMAND_MODE_I,
	input wire logic        DTR_MODE_I,
	input wire logic        HOLD_PIN_IS_RESET_I,
	input wire logic        MEM_RD_REQ_O,
	input wire logic [31:0] MEM_ADDR_O,
	input wire logic        BUSY_O,
	input wire logic        CONT_MODE_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (SRST_I);
	logic        seen;
	logic [31:0] prev;
	wire         held = !HOLD_N_I && !SER_CLK_I && !QUAD_ENABLE_FLAG_I
		&& !DTR_MODE_I && !HOLD_PIN_IS_RESET_I;
	// Remembers the last fetch address within one selection.
	always_ff @(posedge SYS_CLK_I)
	begin
		seen <= !(SRST_I || CHIP_SEL_N_I) && (seen || MEM_RD_REQ_O);
		prev <= MEM_RD_REQ_O ? MEM_ADDR_O : prev;
	end
	////////////////////////////////////////////////////////////////////////
	oe_release_a: assert property (
		$rose(CHIP_SEL_N_I) |-> ##[0:4] IO_OE_O == 4'h0)
		else $error("enable stays on after deselect");
	seq_idle_a: assert property (CHIP_SEL_N_I [*8] |-> !BUSY_O)
		else $error("busy while deselected");
	one_line_a: assert property (
		IO_OE_O != 4'h0 && !FOUR_LINE_COMMAND_MODE_I |-> IO_OE_O == 4'h2)
		else $error("wrong single-line enable");
	four_line_a: assert property (
		IO_OE_O != 4'h0 && FOUR_LINE_COMMAND_MODE_I |-> IO_OE_O == 4'hF)
		else $error("wrong four-line enable");
	addr_mask_a: assert property (
		MEM_RD_REQ_O |-> MEM_ADDR_O[31:25] == 7'h00)
		else $error("undecoded address bit set");
	addr_step_a: assert property (
		MEM_RD_REQ_O && seen |-> MEM_ADDR_O == prev + 32'h0000_0001
		|| MEM_ADDR_O == 32'h0000_0000)
		else $error("address did not step by one");
	hold_off_a: assert property (
		held [*8] ##1 held [*4] |-> IO_OE_O == 4'h0)
		else $error("output driven during pause");
	cont_quad_a: assert property (
		$rose(CONT_MODE_O) |-> FOUR_LINE_COMMAND_MODE_I)
		else $error("continuation armed outside four-line mode");
endmodule

bind sfrp_top sfrp_top_sva sfrp_top_sva_i (.*);

// ==== verif/sfrp_host_model.sv ====
// Host controller model that runs read commands on the serial pins.
module sfrp_host_model (
	input  wire logic       clk_i,
	input  wire logic [3:0] io_o,
	output logic            cs_n_o,
	output logic            sck_o,
	output logic [3:0]      io_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got [2];
	initial
	begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		io_i = 4'h0;
	end
	// One serial clock: drive after the fall, sample before the next fall.
	task automatic tick(input logic [3:0] d, output logic [3:0] q);
		sck_o <= 1'b0;
		io_i <= d;
		repeat (4) @(posedge clk_i);
		sck_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		q = io_o;
	endtask
	// Header goes out MSB first; afterwards the inputs toggle every clock.
	task automatic xfer(input logic [63:0] h, input int hb, dm, input logic qd);
		logic [3:0] q;
		logic [7:0] b;
		cs_n_o <= 1'b0;
		for (int i = hb - 1; i >= 0; i--)
			tick(qd ? h[4*i+:4] : {3'h5, h[i]}, q);
		for (int i = 0; i < dm; i++)
			tick(~io_i, q);
		for (int k = 0; k < 2; k++)
		begin
			for (int j = 0; j < (qd ? 2 : 8); j++)
			begin
				tick(~io_i, q);
				b = qd ? {b[3:0], q} : {b[6:0], q[1]};
			end
			got[k] = b;
		end
		sck_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		cs_n_o <= 1'b1;
		repeat (6) @(posedge clk_i);
	endtask
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the serial flash read path.
module testbench import sfrp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, srst = 1'b1, hold_n = 1'b1, ext = 1'b0;
	logic        write_in_progress_flag = 1'b0, four = 1'b0, cs_n, sck, req;
	logic [3:0]  io_i, io_o;
	logic [7:0]  mem = 8'h00, g0, g1;
	logic [31:0] addr;
	int          miscompares = 0, checks_done = 0, reqs = 0, r0;
	sfrp_top sfrp_top_i (.SYS_CLK_I(clk), .SRST_I(srst), .CHIP_SEL_N_I(cs_n),
		.SER_CLK_I(sck), .HOLD_N_I(hold_n), .IO_I(io_i), .IO_O(io_o),
		.IO_OE_O(), .EXTENDED_ADDRESSING_FLAG_I(ext),
		.WRITE_IN_PROGRESS_FLAG_I(write_in_progress_flag), .QUAD_ENABLE_FLAG_I(1'b0),
		.FOUR_LINE_COMMAND_MODE_I(four), .DTR_MODE_I(1'b0),
		.HOLD_PIN_IS_RESET_I(1'b0), .MEM_RD_REQ_O(req), .MEM_ADDR_O(addr),
		.MEM_DATA_I(mem), .BUSY_O(), .CONT_MODE_O());
	sfrp_host_model sfrp_host_model_i (.clk_i(clk), .io_o(io_o),
		.cs_n_o(cs_n), .sck_o(sck), .io_i(io_i));
	initial
		forever #10 clk = ~clk;
	// Array model: each byte mixes the low and high address bytes.
	always @(posedge clk)
	begin
		mem <= addr[7:0] ^ addr[31:24];
		reqs <= reqs + (req ? 1 : 0);
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic run(input logic [63:0] h, input int hb, dm, input logic q);
		sfrp_host_model_i.xfer(h, hb, dm, q);
		g0 = sfrp_host_model_i.got[0];
		g1 = sfrp_host_model_i.got[1];
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_normal();
		run({NORMAL_READ_CMD, 24'h00_0123}, 32, 0, 1'b0);
		check("normal byte0", g0, 8'h23);
		check("normal byte1", g1, 8'h24);
		ext <= 1'b1;
		run({NORMAL_READ_CMD, 32'h0100_0010}, 40, 0, 1'b0);
		check("extended", g0, 8'h11);
		ext <= 1'b0;
		$display("normal read done");
	endtask
	task automatic t_wrap();
		run({NORMAL_READ_WIDE_ADDR_CMD, 32'hFFFF_FFFF}, 40, 0, 1'b0);
		check("top byte", g0, 8'hFE);
		check("wrapped", g1, 8'h00);
		$display("wrap done");
	endtask
	task automatic t_fast();
		run({FAST_READ_CMD, 24'h00_02F0}, 32, 8, 1'b0);
		check("fast", g1, 8'hF1);
		run({FAST_READ_WIDE_ADDR_CMD, 32'h0000_0407}, 40, 8, 1'b0);
		check("fast wide", g0, 8'h07);
		$display("fast read done");
	endtask
	task automatic t_quad();
		four <= 1'b1;
		run({FAST_READ_CMD, 24'h00_0345}, 8, 6, 1'b1);
		check("quad", g1, 8'h46);
		run(64'h0000_0000_0000_0350, 6, 6, 1'b1);
		check("continued", g0, 8'h50);
		ext <= 1'b1;
		run({UNIQUE_ID_READ_CMD, 24'h00_000F}, 8, 6, 1'b1);
		check("unique id", g0, 8'h0F);
		ext <= 1'b0;
		four <= 1'b0;
		$display("four-line read done");
	endtask
	task automatic t_wip();
		hold_n <= 1'b0;
		repeat (16) @(posedge clk);
		hold_n <= 1'b1;
		write_in_progress_flag <= 1'b1;
		r0 = reqs;
		run({NORMAL_READ_CMD, 24'h00_0010}, 32, 0, 1'b0);
		check("refused fetches", 8'(reqs - r0), 8'h00);
		write_in_progress_flag <= 1'b0;
		$display("busy refusal done");
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		t_normal();
		t_wrap();
		t_fast();
		t_quad();
		t_wip();
		report_and_stop();
	end
endmodule
